//--- core/ssp_map.svh
// Constants for the six-step PWM commutation controller
// Summary of operation
// R1 - Timer period set by half-period compare value
// R2 - Up-down count, frequency clock over 2P-1
// R3 - New duty command capped at upper limit
// R4 - Applied duty never below lower limit
// R5 - Duty ramps one count per rate periods
// R6 - Blocked rotor timeout disables all PWM
// R7 - Startup SPI writes six words, 1 ms gaps
// R8 - High side PWM, same-phase low freewheels
// R9 - Gate driver inserts 100 ns dead time
// R10 - Dead time starts after gate handshake
// R11 - Low side complementary to high side
// R12 - Hall change raises event, selects step
// R13 - Overcurrent cuts cycle, sustained latches off
// R14 - Direction sampled only after reset release
// R15 - Hall state maps to six patterns, reversible
`ifndef SSP_MAP_SVH
`define SSP_MAP_SVH

`define SSP_SYS_CLK_NS      100
`define SSP_STALL_UNIT      30000
`define SSP_WRITE_WAIT_NS   1000000
`define SSP_WRITE_WAIT_CYC  (`SSP_WRITE_WAIT_NS / `SSP_SYS_CLK_NS)
`define SSP_SPI_HALF        14'h0005
`define SSP_OC_LATCH        4'h8
`define SSP_INIT_LAST       3'h5
`define SSP_SPI_WRITE       1'b0
`define SSP_W0_ADDR         4'h3
`define SSP_W0_DATA         11'h3bf
`define SSP_W2_ADDR         4'h2
`define SSP_W2_DATA         11'h100
`define SSP_W3_ADDR         4'h4
`define SSP_W3_DATA         11'h6ff
`define SSP_W4_ADDR         4'h5
`define SSP_W4_DATA         11'h160
`define SSP_W5_ADDR         4'h6
`define SSP_W5_DATA         11'h683

`endif

//--- core/ssp_pkg.sv
// Types shared by the six-step PWM commutation controller
package ssp_pkg;

  typedef struct packed {
    logic hallC;
    logic hallB;
    logic hallA;
  } ssp_hall_s;

  typedef struct packed {
    logic [2:0] hi;
    logic [2:0] lo;
  } ssp_gate_s;

  typedef enum logic [3:0] {
    SPI_IDLE  = 4'h1,
    SPI_SHIFT = 4'h2,
    SPI_WAIT  = 4'h4,
    SPI_DONE  = 4'h8
  } ssp_spi_state_e;

  typedef struct packed {
    ssp_spi_state_e st;
    logic [2:0]     idx;
    logic [3:0]     bitIdx;
    logic [13:0]    cnt;
    logic           phase;
    logic           csN;
    logic           sclk;
    logic           mosi;
  } ssp_spi_s;

  typedef struct packed {
    logic [15:0] cnt;
    logic        down;
    logic [15:0] target;
    logic [15:0] duty;
    logic [15:0] applied;
    logic [15:0] rampCnt;
    ssp_hall_s   prevHall;
    logic        hallEvent;
    logic [2:0]  step;
    logic        stepValid;
    logic        dirRev;
    logic        dirTaken;
    logic [14:0] prescale;
    logic [15:0] stallUnits;
    logic        stalled;
    logic        ocCut;
    logic        ocPeriod;
    logic [3:0]  ocRun;
    logic        ocLatched;
    ssp_gate_s   gate;
  } ssp_core_s;

endpackage

//--- core/ssp_spi_init.sv
// Startup sequencer writing the gate driver configuration over SPI
`timescale 1ns/1ps
`include "ssp_map.svh"
module ssp_spi_init #(
  parameter int WAIT_CYCLES = `SSP_WRITE_WAIT_CYC
) (
  input  wire logic sys_clk,
  input  wire logic rstn,
  output logic      spiCsN,
  output logic      spiSclk,
  output logic      spiMosi,
  output logic      initDone
);
  ssp_pkg::ssp_spi_s s;
  ssp_pkg::ssp_spi_s next_s;

  function automatic logic [15:0] initWord(input logic [2:0] idx);
    case (idx)
      3'h0, 3'h1: initWord = {`SSP_SPI_WRITE, `SSP_W0_ADDR, `SSP_W0_DATA};
      3'h2:       initWord = {`SSP_SPI_WRITE, `SSP_W2_ADDR, `SSP_W2_DATA};
      3'h3:       initWord = {`SSP_SPI_WRITE, `SSP_W3_ADDR, `SSP_W3_DATA};
      3'h4:       initWord = {`SSP_SPI_WRITE, `SSP_W4_ADDR, `SSP_W4_DATA};
      default:    initWord = {`SSP_SPI_WRITE, `SSP_W5_ADDR, `SSP_W5_DATA};
    endcase
  endfunction

  always_comb begin
    logic [15:0] word;
    word = initWord(s.idx);
    next_s = s;
    case (s.st)
      ssp_pkg::SPI_IDLE: begin
        next_s.st = ssp_pkg::SPI_SHIFT;
        next_s.csN = 1'b0;
        next_s.cnt = 14'h0000;
        next_s.phase = 1'b0;
        next_s.bitIdx = 4'hf;
        next_s.mosi = word[15];
      end
      ssp_pkg::SPI_SHIFT: begin
        if (s.cnt == `SSP_SPI_HALF - 14'h0001) begin
          next_s.cnt = 14'h0000;
          next_s.phase = ~s.phase;
          next_s.sclk = ~s.phase;
          if (s.phase && s.bitIdx == 4'h0) begin
            next_s.st = ssp_pkg::SPI_WAIT;
            next_s.csN = 1'b1;
            next_s.mosi = 1'b0;
          end else if (s.phase) begin
            next_s.bitIdx = s.bitIdx - 4'h1;
            next_s.mosi = word[s.bitIdx - 4'h1];
          end
        end else begin
          next_s.cnt = s.cnt + 14'h0001;
        end
      end
      ssp_pkg::SPI_WAIT: begin
        if (s.cnt == 14'(WAIT_CYCLES - 1)) begin // R7
          next_s.cnt = 14'h0000;
          if (s.idx == `SSP_INIT_LAST) begin
            next_s.st = ssp_pkg::SPI_DONE;
          end else begin
            next_s.idx = s.idx + 3'h1;
            next_s.st = ssp_pkg::SPI_IDLE;
          end
        end else begin
          next_s.cnt = s.cnt + 14'h0001;
        end
      end
      ssp_pkg::SPI_DONE: next_s.st = ssp_pkg::SPI_DONE;
      default: next_s.st = ssp_pkg::SPI_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '{st: ssp_pkg::SPI_IDLE, csN: 1'b1, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign spiCsN = s.csN;
  assign spiSclk = s.sclk;
  assign spiMosi = s.mosi;
  assign initDone = (s.st == ssp_pkg::SPI_DONE);

  property p_gap;
    @(posedge sys_clk) disable iff (!rstn)
      $rose(spiCsN) |=> spiCsN [*4];
  endproperty
  a_gap: assert property (p_gap) else $error("Chip select fell too soon"); // R7

  property p_done_idle;
    @(posedge sys_clk) disable iff (!rstn)
      initDone |=> initDone && spiCsN && !spiSclk;
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("SPI busy after done"); // R7
endmodule

//--- core/ssp_pwm_core.sv
// Six-step commutation controller with centre-aligned PWM
`timescale 1ns/1ps
`include "ssp_map.svh"
module ssp_pwm_core #(
  parameter int STALL_UNIT_CYC = `SSP_STALL_UNIT,
  parameter int WRITE_WAIT_CYC = `SSP_WRITE_WAIT_CYC
) (
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  input  wire logic [15:0]       halfPeriod,
  input  wire logic [15:0]       dutyCmd,
  input  wire logic              dutyCmdValid,
  input  wire logic [15:0]       dutyUpperLimit,
  input  wire logic [15:0]       dutyLowerLimit,
  input  wire logic [15:0]       rampRateSetting,
  input  wire logic [15:0]       stallTimeout,
  input  wire ssp_pkg::ssp_hall_s hall,
  input  wire logic              dirReverse,
  input  wire logic              ocComp,
  output ssp_pkg::ssp_gate_s     gate,
  output logic                   hallEvent,
  output logic [15:0]            appliedDuty,
  output logic                   stalled,
  output logic                   ocLatched,
  output logic                   initDone,
  output logic                   spiCsN,
  output logic                   spiSclk,
  output logic                   spiMosi
);
  ssp_pkg::ssp_core_s s;
  ssp_pkg::ssp_core_s next_s;

  // Valid hall code to step, bit 3 flags a valid code
  function automatic logic [3:0] hallStep(input ssp_pkg::ssp_hall_s h);
    case (h)
      3'h5:    hallStep = 4'h8;
      3'h4:    hallStep = 4'h9;
      3'h6:    hallStep = 4'ha;
      3'h2:    hallStep = 4'hb;
      3'h3:    hallStep = 4'hc;
      3'h1:    hallStep = 4'hd;
      default: hallStep = 4'h0;
    endcase
  endfunction

  // Step to driven phases: high side carries PWM, its low side freewheels
  function automatic ssp_pkg::ssp_gate_s pattern(input logic [2:0] step,
                                                 input logic       pwm);
    logic [1:0] hiPh;
    logic [1:0] loPh;
    case (step)
      3'h0:    begin hiPh = 2'h0; loPh = 2'h1; end
      3'h1:    begin hiPh = 2'h0; loPh = 2'h2; end
      3'h2:    begin hiPh = 2'h1; loPh = 2'h2; end
      3'h3:    begin hiPh = 2'h1; loPh = 2'h0; end
      3'h4:    begin hiPh = 2'h2; loPh = 2'h0; end
      default: begin hiPh = 2'h2; loPh = 2'h1; end
    endcase
    pattern = '0;
    pattern.hi[hiPh] = pwm; // R8
    pattern.lo[hiPh] = ~pwm; // R11
    pattern.lo[loPh] = 1'b1; // R8
  endfunction

  ssp_spi_init #(
    .WAIT_CYCLES(WRITE_WAIT_CYC)
  ) u_spi (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .spiCsN   (spiCsN),
    .spiSclk  (spiSclk),
    .spiMosi  (spiMosi),
    .initDone (initDone)
  );

  always_comb begin
    logic       pStart;
    logic       enable;
    logic       pwm;
    logic [3:0] hs;
    logic [2:0] st;
    logic [3:0] run;
    logic       rev;
    pStart = (s.cnt == 16'h0000) && !s.down;
    pwm = 1'b0;
    // First edge after reset uses the pin, before the capture lands
    rev = s.dirTaken ? s.dirRev : dirReverse; // R14
    enable = initDone && !s.stalled && !s.ocLatched && s.stepValid;
    hs = hallStep(hall);
    st = hs[2:0];
    run = s.ocRun + 4'h1;
    next_s = s;
    next_s.prevHall = hall;
    next_s.hallEvent = (hall != s.prevHall); // R12
    if (!s.dirTaken) begin
      next_s.dirRev = dirReverse; // R14
      next_s.dirTaken = 1'b1;
    end
    if (!s.down) begin
      if (s.cnt >= halfPeriod - 16'h0001) begin
        next_s.down = 1'b1; // R1
      end else begin
        next_s.cnt = s.cnt + 16'h0001;
      end
    end else if (s.cnt <= 16'h0001) begin
      next_s.cnt = 16'h0000; // R2
      next_s.down = 1'b0;
    end else begin
      next_s.cnt = s.cnt - 16'h0001;
    end
    if (dutyCmdValid) begin
      next_s.target = (dutyCmd > dutyUpperLimit) ? dutyUpperLimit
                                                 : dutyCmd; // R3
    end
    if (pStart) begin
      if (s.rampCnt + 16'h0001 >= rampRateSetting) begin // R5
        next_s.rampCnt = 16'h0000;
        if (s.duty < s.target) begin
          next_s.duty = s.duty + 16'h0001; // R5
        end else if (s.duty > s.target) begin
          next_s.duty = s.duty - 16'h0001; // R5
        end
      end else begin
        next_s.rampCnt = s.rampCnt + 16'h0001;
      end
    end
    next_s.applied = (s.duty < dutyLowerLimit) ? dutyLowerLimit
                                               : s.duty; // R4
    if (hall != s.prevHall) begin
      next_s.stepValid = hs[3]; // R15
      if (rev) begin
        next_s.step = (st >= 3'h3) ? st - 3'h3 : st + 3'h3; // R15
      end else begin
        next_s.step = st;
      end
    end
    if (s.hallEvent || !enable || s.applied == 16'h0000) begin
      next_s.prescale = 15'h0000;
      next_s.stallUnits = 16'h0000;
    end else if (s.prescale == 15'(STALL_UNIT_CYC - 1)) begin
      next_s.prescale = 15'h0000;
      next_s.stallUnits = s.stallUnits + 16'h0001;
    end else begin
      next_s.prescale = s.prescale + 15'h0001;
    end
    if (stallTimeout != 16'h0000 && s.stallUnits >= stallTimeout) begin
      next_s.stalled = 1'b1; // R6
    end
    if (pStart) begin
      next_s.ocCut = 1'b0;
      next_s.ocPeriod = 1'b0;
      next_s.ocRun = s.ocPeriod ? run : 4'h0;
      if (s.ocPeriod && run >= `SSP_OC_LATCH) begin
        next_s.ocLatched = 1'b1; // R13
      end
    end
    if (ocComp) begin
      next_s.ocCut = 1'b1; // R13
      next_s.ocPeriod = 1'b1;
    end
    pwm = (s.cnt < s.applied) && !s.ocCut && !ocComp; // R13
    next_s.gate = enable ? pattern(s.step, pwm) : '0; // R6
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign gate = s.gate;
  assign hallEvent = s.hallEvent;
  assign appliedDuty = s.applied;
  assign stalled = s.stalled;
  assign ocLatched = s.ocLatched;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  property p_turn;
    (!s.down && s.cnt == halfPeriod - 16'h0001 && $stable(halfPeriod))
      |=> s.down && s.cnt == $past(s.cnt);
  endproperty
  a_turn: assert property (p_turn) else $error("Timer missed peak"); // R2

  property p_bottom;
    (s.down && s.cnt == 16'h0001) |=> (!s.down && s.cnt == 16'h0000);
  endproperty
  a_bottom: assert property (p_bottom) else $error("Timer missed valley"); // R1

  property p_cap;
    (dutyCmdValid && dutyCmd > dutyUpperLimit)
      |=> s.target == $past(dutyUpperLimit);
  endproperty
  a_cap: assert property (p_cap) else $error("Target above limit"); // R3

  property p_floor;
    1'b1 |=> appliedDuty >= $past(dutyLowerLimit);
  endproperty
  a_floor: assert property (p_floor) else $error("Duty below floor"); // R4

  property p_ramp;
    (s.duty != $past(s.duty)) |-> (s.duty == $past(s.duty) + 16'h0001
      || s.duty == $past(s.duty) - 16'h0001);
  endproperty
  a_ramp: assert property (p_ramp) else $error("Duty jumped"); // R5

  property p_stall;
    stalled |=> gate == '0 [*3];
  endproperty
  a_stall: assert property (p_stall) else $error("Gates on when stalled"); // R6

  property p_event;
    (hall != s.prevHall) |=> hallEvent;
  endproperty
  a_event: assert property (p_event) else $error("Hall event missing"); // R12

  property p_quiet;
    (hall == s.prevHall) |=> !hallEvent;
  endproperty
  a_quiet: assert property (p_quiet) else $error("Stray hall event"); // R12

  property p_oclatch;
    ocLatched |=> gate.hi == 3'h0 && gate.lo == 3'h0;
  endproperty
  a_oclatch: assert property (p_oclatch) else $error("Gates on after trip"); // R13

  property p_cut;
    ocComp |=> gate.hi == 3'h0;
  endproperty
  a_cut: assert property (p_cut) else $error("PWM not cut"); // R13

  property p_dir;
    s.dirTaken |=> $stable(s.dirRev);
  endproperty
  a_dir: assert property (p_dir) else $error("Direction changed"); // R14

  property p_compl;
    (gate.hi & gate.lo) == 3'h0;
  endproperty
  a_compl: assert property (p_compl) else $error("Shoot-through"); // R11

  c_event: cover property (hallEvent && initDone);
  c_stall: cover property ($rose(stalled));
  c_oc: cover property ($rose(ocLatched));
  c_rev: cover property (s.dirRev && gate.hi != 3'h0);
endmodule

//--- verif/ssp_drv_model.sv
// Gate driver and Hall sensor model facing the commutation controller
`timescale 1ns/1ps
module ssp_drv_model (
  input  wire logic               sys_clk,
  input  wire logic               rstn,
  input  wire logic [2:0]         hallCode,
  input  wire ssp_pkg::ssp_gate_s gate,
  input  wire logic               spiCsN,
  input  wire logic               spiSclk,
  input  wire logic               spiMosi,
  output ssp_pkg::ssp_hall_s      hall,
  output logic [2:0]              hiOn,
  output logic [2:0]              loOn,
  output logic [15:0]             rxWord [6],
  output int                      rxCount
);
  logic [15:0] sh;
  int          nb;
  assign hall = hallCode;
  // A switch turns on only once its partner has been off for a clock
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hiOn <= '0;
      loOn <= '0;
    end else begin
      hiOn <= gate.hi & ~gate.lo & ~loOn;
      loOn <= gate.lo & ~gate.hi & ~hiOn;
    end
  end
  // Word capture on the rising SPI clock
  always @(posedge spiSclk or negedge rstn) begin
    if (!rstn) begin
      rxCount <= 0;
      nb = 0;
    end else if (!spiCsN) begin
      sh = {sh[14:0], spiMosi};
      nb++;
      if (nb == 16 && rxCount < 6) begin
        rxWord[rxCount] <= sh;
        rxCount <= rxCount + 1;
      end
      if (nb == 16) begin
        nb = 0;
      end
    end
  end
endmodule

//--- verif/tb.sv
// Self-checking bench for the six-step PWM commutation controller
`timescale 1ns/1ps
module tb;
  localparam int P = 10;
  localparam int PER = 2 * P - 1;
  localparam int UPL = 15;
  localparam int LOL = 3;
  localparam int RATE = 2;
  logic               sys_clk, rstn, dutyCmdValid, dirReverse, ocComp;
  logic [15:0]        halfPeriod, dutyCmd, dutyUpperLimit, dutyLowerLimit;
  logic [15:0]        rampRateSetting, stallTimeout, appliedDuty, v;
  logic [2:0]         hallCode, hm, lm, hiOn, loOn;
  ssp_pkg::ssp_hall_s hall;
  ssp_pkg::ssp_gate_s gate;
  logic               hallEvent, stalled, ocLatched, initDone;
  logic               spiCsN, spiSclk, spiMosi, sawH, sawL;
  logic [15:0]        rxWord [6];
  int rxCount, err_total, comparisons, cyc, seed, t0, hit, tgt, s;
  int ord [6] = '{5, 4, 6, 2, 3, 1};
  int hiPh [6] = '{0, 0, 1, 1, 2, 2};
  int loPh [6] = '{1, 2, 2, 0, 0, 1};
  int wAd [6] = '{3, 3, 2, 4, 5, 6};
  int wDa [6] = '{'h3bf, 'h3bf, 'h100, 'h6ff, 'h160, 'h683};

  ssp_pwm_core #(.STALL_UNIT_CYC(10), .WRITE_WAIT_CYC(4)) u_ssp_pwm_core (
    .sys_clk, .rstn, .halfPeriod, .dutyCmd, .dutyCmdValid, .dutyUpperLimit,
    .dutyLowerLimit, .rampRateSetting, .stallTimeout, .hall, .dirReverse,
    .ocComp, .gate, .hallEvent, .appliedDuty, .stalled, .ocLatched,
    .initDone, .spiCsN, .spiSclk, .spiMosi);
  ssp_drv_model u_ssp_drv_model (
    .sys_clk, .rstn, .hallCode, .gate, .spiCsN, .spiSclk, .spiMosi, .hall,
    .hiOn, .loOn, .rxWord, .rxCount);

  initial begin
    sys_clk = 0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic complete_run();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      complete_run();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #5;
  endtask

  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task automatic doReset(input logic dir);
    rstn = 0;
    dirReverse = dir;
    tick(4);
    chk(spiCsN === 1'b1 && gate === '0 && appliedDuty === '0, "reset");
    rstn = 1;
    hit = 0;
    while (initDone !== 1'b1 && hit < 2000) begin
      tick(1);
      hit++;
    end
    chk(rxCount == 6 && spiCsN === 1'b1, "spi count");
    for (int i = 0; i < 6; i++) begin
      chk(rxWord[i] === {1'b0, wAd[i][3:0], wDa[i][10:0]}, "spi word");
    end
  endtask

  task automatic setDuty(input int cmd);
    dutyCmd = cmd[15:0];
    dutyCmdValid = 1;
    tick(1);
    dutyCmdValid = 0;
    tgt = cmd > UPL ? UPL : cmd;
    tgt = tgt < LOL ? LOL : tgt;
  endtask

  task automatic waitChange();
    v = appliedDuty;
    hit = 0;
    while (appliedDuty === v && hit < 200) begin
      tick(1);
      hit++;
    end
  endtask

  task automatic commute(input int rev);
    for (int k = 0; k < 6; k++) begin
      hallCode = ord[k][2:0];
      if (k == 3) begin
        dirReverse = ~dirReverse;
      end
      s = (k + 3 * rev) % 6;
      hm = 3'b1 << hiPh[s];
      lm = 3'b1 << loPh[s];
      hit = 0;
      repeat (4) begin
        tick(1);
        hit += (hallEvent === 1'b1);
      end
      chk(hit == 1, "hall event pulse");
      sawH = 0;
      sawL = 0;
      repeat (PER) begin
        tick(1);
        sawH |= gate.hi[hiPh[s]];
        sawL |= gate.lo[hiPh[s]];
        chk((gate.hi & ~hm) === '0 && (gate.lo & ~hm) === lm, "legs");
        chk(gate.hi[hiPh[s]] !== gate.lo[hiPh[s]], "complement");
        chk((hiOn & loOn) === 3'h0 && loOn[loPh[s]] === 1'b1,
            "driver legs");
      end
      chk(sawH === 1'b1 && sawL === 1'b1, "pwm on active leg");
    end
  endtask

  initial begin
    {cyc, err_total, comparisons, seed} = {32'd0, 32'd0, 32'd0, 32'd13};
    {dutyCmd, dutyCmdValid, ocComp, hallCode} = '0;
    {halfPeriod, dutyUpperLimit, dutyLowerLimit} = {16'h000a, 16'h000f, 16'h0003};
    {rampRateSetting, stallTimeout} = {RATE[15:0], 16'h0000};
    doReset(0);
    setDuty(100);
    waitChange();
    waitChange();
    t0 = cyc;
    waitChange();
    chk(cyc - t0 == RATE * PER && appliedDuty === v + 16'h1, "ramp");
    tick(30 * PER);
    chk(appliedDuty === UPL[15:0], "upper clamp");
    rampRateSetting = 16'h0;
    for (int i = 0; i < 4; i++) begin
      setDuty(i == 0 ? 0 : $random(seed) & 31);
      tick(20 * PER);
      chk(appliedDuty === tgt[15:0], "clamped duty");
    end
    chk(gate === '0, "no valid hall yet");
    // Duty below the half period so the active leg really toggles
    setDuty(6);
    tick(20 * PER);
    commute(0);
    hallCode = 3'h7;
    tick(4);
    chk(gate === '0, "invalid hall");
    hallCode = 3'h5;
    tick(4);
    ocComp = 1;
    tick(1);
    chk(gate.hi === '0, "cycle cut");
    tick(6 * PER);
    chk(ocLatched === 1'b0, "not latched early");
    tick(3 * PER);
    ocComp = 0;
    tick(2 * PER);
    chk(ocLatched === 1'b1 && gate.hi === '0, "latched off");
    hallCode = 3'h0;
    doReset(1);
    commute(1);
    hallCode = 3'h5;
    tick(2);
    stallTimeout = 16'h2;
    hit = 0;
    while (stalled !== 1'b1 && hit < 60) begin
      tick(1);
      hit++;
    end
    chk(hit >= 20 && hit <= 26, "stall time");
    tick(2);
    chk(gate === '0, "stall off");
    complete_run();
  end
endmodule
